// [bench/maiw_adc_model.sv]
module maiw_adc_model
    import maiw_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [95:0] mag_tab,
    input wire logic [7:0] neg_tab,
    output logic adc_valid,
    output logic [2:0] adc_chan,
    output logic [11:0] adc_mag,
    output logic adc_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap;
    maiw_ch_t ch;
    // Conversions free-run on a fixed cadence that ignores the scans.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap <= 2'h0;
            ch <= 3'h0;
            adc_valid <= 1'b0;
            adc_chan <= 3'h0;
            adc_mag <= 12'h000;
            adc_neg <= 1'b0;
        end else begin
            gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
            adc_valid <= (gap == 2'h2);
            if (gap == 2'h2) begin
                adc_chan <= ch;
                adc_mag <= mag_tab[ch * 12 +: 12];
                adc_neg <= neg_tab[ch];
                ch <= ch + 3'h1;
            end else begin
                // Between strobes the lines toggle: first the inverted sample, then the sample again.
                adc_chan <= ~adc_chan;
                adc_mag <= ~adc_mag;
                adc_neg <= ~adc_neg;
            end
        end
    end
endmodule

// [bench/tb.sv]
`include "maiw_map.svh"
module tb
    import maiw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] NEG = 8'h89;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_ok = 1'b1, scan_start = 1'b0, word_req = 1'b0;
    logic [2:0] chan_cnt_sel = 3'h7;
    logic adc_valid, adc_neg, id0, id1, id2, irq;
    logic [2:0] adc_chan;
    logic [11:0] adc_mag;
    maiw_word_t in_word;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [95:0] mag_tab;
    int mismatches = 0, checked = 0;

    maiw_adc_model maiw_adc_model_inst (.clk(clk), .sys_rst(sys_rst),
        .mag_tab(mag_tab), .neg_tab(NEG), .adc_valid(adc_valid),
        .adc_chan(adc_chan), .adc_mag(adc_mag), .adc_neg(adc_neg));
    maiw_core maiw_core_inst (.clk(clk), .sys_rst(sys_rst),
        .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_mag(adc_mag),
        .adc_neg(adc_neg), .supply_ok(supply_ok),
        .chan_cnt_sel(chan_cnt_sel), .scan_start(scan_start),
        .word_req(word_req), .in_word(in_word), .chan_id_bit0(id0),
        .chan_id_bit1(id1), .chan_id_bit2(id2), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    always #5 clk = ~clk;

    function automatic maiw_mag_t mag_of(int c);
        return (c == 7) ? 12'hFFF : 12'(c * 12'h123);
    endfunction
    function automatic maiw_word_t exp_w(int c);
        maiw_mag_t m;
        m = mag_of(c);
        return {NEG[c] && (m != 12'h000), 3'(c), m};
    endfunction
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (bvalid !== 1'b1) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic scan(input logic w);
        @(posedge clk);
        scan_start <= !w;
        word_req <= w;
        @(posedge clk);
        scan_start <= 1'b0;
        word_req <= 1'b0;
        tick(2);
    endtask
    task automatic chk_word(int c);
        chk("in_word", exp_w(c), in_word);
        chk("chan_id", c, {id2, id1, id0});
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        chk("in_word", 0, in_word);
        chk("irq", 0, irq);
        rd(`MAIW_OFS_IMR, d, r);
        chk("imr", 0, d);
        rd(`MAIW_OFS_CTRL, d, r);
        chk("ctrl", 0, d);
    endtask
    task automatic t_mux(input logic [2:0] sel, input int n);
        chan_cnt_sel <= sel;
        for (int k = 0; k < n; k++) begin
            scan(1'b0);
            chk_word(k % (int'(sel) + 1));
        end
    endtask
    task automatic t_ptr();
        logic [1:0] r;
        wr(`MAIW_OFS_CTRL, 32'h0000_0001, r);
        chk("bresp", `MAIW_RESP_OK, r);
        scan(1'b0);
        chk_word(0);
        for (int k = 1; k < 8; k++) begin
            scan(1'b1);
            chk_word(k);
        end
        wr(`MAIW_OFS_CTRL, 32'h0000_0000, r);
        scan(1'b1);
        chk_word(7);
    endtask
    task automatic t_fault();
        logic [31:0] d;
        logic [1:0] r;
        wr(`MAIW_OFS_ISR, 32'h0000_0007, r);
        wr(`MAIW_OFS_IMR, 32'h0000_0000, r);
        supply_ok <= 1'b0;
        tick(4);
        chk("irq masked", 0, irq);
        rd(`MAIW_OFS_STAT, d, r);
        chk("stat fault", 1, d[0]);
        wr(`MAIW_OFS_IMR, 32'h0000_0002, r);
        tick(2);
        chk("irq", 1, irq);
        scan(1'b0);
        chk("fault word", 32'h0000_1000, {in_word[15], in_word[11:0]});
        supply_ok <= 1'b1;
        wr(`MAIW_OFS_ISR, 32'h0000_0002, r);
        tick(2);
        chk("irq cleared", 0, irq);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(`MAIW_OFS_STAT, d, r);
        chk("stat", 32'h0000_0720, d);
        rd(`MAIW_OFS_WORD, d, r);
        chk("word reg", exp_w(1), d);
        rd(`MAIW_OFS_ISR, d, r);
        chk("isr", 32'h0000_0005, d);
        wr(`MAIW_OFS_ISR, 32'h0000_0001, r);
        rd(`MAIW_OFS_ISR, d, r);
        chk("isr wrap clear", 32'h0000_0004, d);
    endtask
    task automatic t_err();
        logic [31:0] d;
        logic [1:0] r;
        rd(8'h20, d, r);
        chk("rresp", `MAIW_RESP_ERR, r);
        chk("rdata", 0, d);
        wr(8'h20, 32'h0000_0001, r);
        chk("bresp", `MAIW_RESP_ERR, r);
    endtask

    initial begin
        for (int i = 0; i < 8; i++) mag_tab[i * 12 +: 12] = mag_of(i);
        tick(8);
        sys_rst <= 1'b0;
        t_reset();
        // Long enough for every channel filter to snap onto its input.
        tick(1500);
        t_mux(3'h1, 4);
        t_mux(3'h7, 10);
        t_regs();
        t_ptr();
        t_fault();
        t_err();
        end_sim();
    end
    initial begin
        tick(20000);
        mismatches++;
        end_sim();
    end
endmodule

// [hw/maiw_core.sv]
`include "maiw_map.svh"
// Overview of operation
// - Multiplexed mode hands over exactly one channel per scan.
// - After the last enabled channel the sequence restarts at channel 1.
// - Channels beyond the enabled count are skipped.
// - Pointer mode supplies every enabled channel within one scan.
// - Conversion results are stored continuously, independent of scans.
// - Reported data settles to 95 percent of a step in about 4 ms.
// - The CPU sees one 16-point input word.
// - Bits 0 to 11 hold the binary result, bit n weighs 2^n.
// - Channel id bits hold channel minus one, lowest bit least significant.
// - Channel id bits follow the reported channel on every scan.
// - Missing supply sets the top bit and forces data to zero.
// - With non-zero data the top bit is the sign.
// - Unipolar results span codes 0 to 4095.
// - Bipolar results are sign plus 12-bit magnitude, 4095 full scale.
// - One count is span over 4095 or 8190.
// - Word holds 12 data, 3 id and one shared sign/diagnostic bit.
// - Count inputs weighted 1, 2, 4 enable value plus one channels.
module maiw_core
    import maiw_pkg::*;
#(
    parameter int NCH = `MAIW_NCH,
    parameter int FILT_SHIFT = `MAIW_FILT_SHIFT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic adc_valid,
    input wire logic [2:0] adc_chan,
    input wire logic [11:0] adc_mag,
    input wire logic adc_neg,
    input wire logic supply_ok,
    input wire logic [2:0] chan_cnt_sel,
    input wire logic scan_start,
    input wire logic word_req,
    output logic [15:0] in_word,
    output logic chan_id_bit0,
    output logic chan_id_bit1,
    output logic chan_id_bit2,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    if (NCH != 8 || FILT_SHIFT < 1 || FILT_SHIFT > 6) begin : g_chk
        $error("maiw_core: NCH must be 8 and FILT_SHIFT 1 to 6");
    end

    localparam maiw_acc_t FLIM = maiw_acc_t'(1) <<< FILT_SHIFT;

    function automatic maiw_ch_t next_ch(maiw_ch_t c, maiw_ch_t last);
        next_ch = (c >= last) ? 3'h0 : c + 3'h1;
    endfunction

    // A plain first-order filter stalls short of the target; snapping
    // once the error is below one step gives the exact final code.
    function automatic maiw_acc_t filt_step(maiw_acc_t y, maiw_acc_t x);
        maiw_acc_t d;
        d = x - y;
        if (d < FLIM && d > -FLIM) begin
            filt_step = x;
        end else begin
            filt_step = y + (d >>> FILT_SHIFT);
        end
    endfunction

    function automatic maiw_mag_t mag_of(maiw_acc_t y);
        maiw_acc_t a;
        a = (y < 0) ? -y : y;
        if (a > $signed({2'b00, `MAIW_FULL})) begin
            mag_of = `MAIW_FULL;
        end else begin
            mag_of = a[11:0];
        end
    endfunction

    function automatic maiw_word_t build_word(logic flt, maiw_acc_t y,
                                              maiw_ch_t id);
        maiw_mag_t m;
        m = mag_of(y);
        if (flt) begin
            build_word = {1'b1, id, 12'h000};
        end else begin
            build_word = {(y < 0) && (m != 12'h000), id, m};
        end
    endfunction

    // Converter store, one filtered value per channel.
    maiw_acc_t filt [NCH];
    maiw_ch_t seq_ch;
    maiw_mode_t mode;
    logic [2:0] isr;
    logic [2:0] imr;
    logic fault_q;

    wire maiw_ch_t last = chan_cnt_sel;
    wire conv_take = adc_valid && (adc_chan <= last);
    wire maiw_acc_t smp = adc_neg ? -$signed({2'b00, adc_mag})
                                  : $signed({2'b00, adc_mag});
    wire ptr_mode = (mode == MAIW_PTR);
    wire take_req = ptr_mode && word_req && !scan_start;
    wire deliver = scan_start || take_req;
    wire maiw_ch_t cur_ch = (seq_ch > last) ? 3'h0 : seq_ch;
    wire maiw_ch_t del_ch = (ptr_mode && scan_start) ? 3'h0 : cur_ch;
    wire maiw_ch_t next_seq = next_ch(del_ch, last);
    wire wrap_ev = deliver && (del_ch == last);
    wire flt = !supply_ok;
    wire fault_ev = flt && !fault_q;
    wire maiw_word_t next_word = build_word(flt, filt[del_ch], del_ch);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NCH; i++) begin
                filt[i] <= '0;
            end
        end else if (conv_take) begin
            filt[adc_chan] <= filt_step(filt[adc_chan], smp);
        end
    end

    // The word only moves on a hand-over, so a CPU read between two
    // hand-overs always sees data, id and sign of the same channel.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_ch <= 3'h0;
            in_word <= 16'h0000;
            chan_id_bit0 <= 1'b0;
            chan_id_bit1 <= 1'b0;
            chan_id_bit2 <= 1'b0;
        end else if (deliver) begin
            seq_ch <= next_seq;
            in_word <= next_word;
            chan_id_bit0 <= del_ch[0];
            chan_id_bit1 <= del_ch[1];
            chan_id_bit2 <= del_ch[2];
        end
    end

    // Register bus: address and data are taken together, one at a time.
    wire aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                 && !s_axi_bvalid;
    wire wr_en = s_axi_awready && s_axi_wready;
    wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire wr_ctrl = wr_en && wa == `MAIW_OFS_CTRL && s_axi_wstrb[0];
    wire wr_isr = wr_en && wa == `MAIW_OFS_ISR && s_axi_wstrb[0];
    wire wr_imr = wr_en && wa == `MAIW_OFS_IMR && s_axi_wstrb[0];
    wire wr_ok = wa == `MAIW_OFS_CTRL || wa == `MAIW_OFS_STAT
                 || wa == `MAIW_OFS_ISR || wa == `MAIW_OFS_IMR
                 || wa == `MAIW_OFS_WORD;
    wire [2:0] isr_clr = wr_isr ? s_axi_wdata[2:0] : 3'h0;
    wire [2:0] isr_set = {conv_take, fault_ev, wrap_ev};
    wire [31:0] stat_val = {21'h00_0000, last, 1'b0, cur_ch, 3'h0, flt};
    wire rd_ok = ra == `MAIW_OFS_CTRL || ra == `MAIW_OFS_STAT
                 || ra == `MAIW_OFS_ISR || ra == `MAIW_OFS_IMR
                 || ra == `MAIW_OFS_WORD;
    wire [31:0] rd_val =
        (ra == `MAIW_OFS_CTRL) ? {31'h0000_0000, ptr_mode} :
        (ra == `MAIW_OFS_STAT) ? stat_val :
        (ra == `MAIW_OFS_ISR) ? {29'h0000_0000, isr} :
        (ra == `MAIW_OFS_IMR) ? {29'h0000_0000, imr} :
        (ra == `MAIW_OFS_WORD) ? {16'h0000, in_word} : 32'h0000_0000;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MAIW_RESP_OK;
        end else begin
            s_axi_awready <= aw_go;
            s_axi_wready <= aw_go;
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `MAIW_RESP_OK : `MAIW_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MAIW_RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready
                             && !s_axi_rvalid;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? `MAIW_RESP_OK : `MAIW_RESP_ERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= maiw_mode_t'(`MAIW_CTRL_RST);
            imr <= `MAIW_IMR_RST;
        end else begin
            if (wr_ctrl) begin
                mode <= maiw_mode_t'(s_axi_wdata[`MAIW_CTRL_PTR]);
            end
            if (wr_imr) begin
                imr <= s_axi_wdata[2:0];
            end
        end
    end

    // A new event in the clearing cycle survives: set wins over clear.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            isr <= 3'h0;
            fault_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            isr <= (isr & ~isr_clr) | isr_set;
            fault_q <= flt;
            irq <= |(isr & imr);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_one_per_scan;
        scan_start && !ptr_mode |=> in_word[14:12] == $past(cur_ch);
    endproperty
    a_one_per_scan: assert property (p_one_per_scan)
        else $error("mux scan delivered wrong channel");

    property p_wrap;
        deliver && del_ch == last |=> seq_ch == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("sequence did not wrap to channel 1");

    property p_skip;
        deliver ##1 last == $past(last) |-> seq_ch <= last;
    endproperty
    a_skip: assert property (p_skip)
        else $error("disabled channel entered sequence");

    sequence s_ptr_pair;
        ptr_mode && scan_start && last != 3'h0
            ##1 (!deliver)[*3] ##1 take_req;
    endsequence
    property p_ptr_all;
        s_ptr_pair |=> in_word[14:12] == 3'h1;
    endproperty
    a_ptr_all: assert property (p_ptr_all)
        else $error("pointer transfer did not step to channel 2");

    property p_fault;
        deliver && !supply_ok |=> in_word[15] && in_word[11:0] == 12'h000;
    endproperty
    a_fault: assert property (p_fault)
        else $error("missing supply not reported");

    property p_sign;
        deliver && supply_ok |=> !(in_word[15] && in_word[11:0] == 12'h000);
    endproperty
    a_sign: assert property (p_sign)
        else $error("sign set with zero data");

    property p_id;
        1'b1 |-> {chan_id_bit2, chan_id_bit1, chan_id_bit0}
                 == in_word[14:12];
    endproperty
    a_id: assert property (p_id)
        else $error("id outputs disagree with word");

    property p_hold;
        !deliver |=> $stable(in_word);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word changed without hand-over");

    property p_range;
        1'b1 |-> filt[cur_ch] <= 14'sd4095 && filt[cur_ch] >= -14'sd4095;
    endproperty
    a_range: assert property (p_range)
        else $error("stored value out of range");

    property p_settle;
        conv_take && smp != filt[adc_chan]
            |=> filt[$past(adc_chan)] != $past(filt[adc_chan]);
    endproperty
    a_settle: assert property (p_settle)
        else $error("filter did not move toward input");

    property p_irq;
        1'b1 |=> irq == $past(|(isr & imr));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output wrong");

    sequence s_wr;
        aw_go ##1 wr_en;
    endsequence
    property p_bresp;
        s_wr |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response missing");

    property p_id_enabled;
        deliver |=> in_word[14:12] <= $past(last);
    endproperty
    a_id_enabled: assert property (p_id_enabled)
        else $error("word names a channel beyond the enabled count");

    property p_ptr_first;
        ptr_mode && scan_start |=> in_word[14:12] == 3'h0;
    endproperty
    a_ptr_first: assert property (p_ptr_first)
        else $error("pointer transfer did not start at channel 1");

    property p_unipolar;
        deliver && supply_ok && filt[del_ch] >= 14'sd0
            |=> !in_word[15] && in_word[11:0] == $past(filt[del_ch][11:0]);
    endproperty
    a_unipolar: assert property (p_unipolar)
        else $error("positive value not reported as plain binary");

    property p_flags;
        1'b1 |=> (isr & $past(isr_set)) == $past(isr_set);
    endproperty
    a_flags: assert property (p_flags)
        else $error("event did not set its status bit");

    property p_clear;
        wr_isr && s_axi_wdata[0] && !wrap_ev |=> !isr[0];
    endproperty
    a_clear: assert property (p_clear)
        else $error("status bit survived a clear");

    property p_id_follow;
        deliver |=> {chan_id_bit2, chan_id_bit1, chan_id_bit0}
                    == $past(del_ch);
    endproperty
    a_id_follow: assert property (p_id_follow)
        else $error("id outputs do not name the delivered channel");

    property p_refuse;
        word_req && !ptr_mode && !scan_start |=> $stable(in_word);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("word request moved the word in mux mode");

    property p_bad_resp;
        wr_en && !wr_ok |=> s_axi_bvalid && s_axi_bresp == `MAIW_RESP_ERR;
    endproperty
    a_bad_resp: assert property (p_bad_resp)
        else $error("unmapped write not refused");

endmodule

// [hw/maiw_map.svh]
`ifndef MAIW_MAP_SVH
`define MAIW_MAP_SVH
`define MAIW_OFS_CTRL 8'h00
`define MAIW_OFS_STAT 8'h04
`define MAIW_OFS_ISR 8'h08
`define MAIW_OFS_IMR 8'h0C
`define MAIW_OFS_WORD 8'h10
`define MAIW_CTRL_PTR 0
`define MAIW_CTRL_RST 1'b0
`define MAIW_IMR_RST 3'h0
`define MAIW_STAT_FAULT 0
`define MAIW_STAT_SEQ_LSB 4
`define MAIW_STAT_LAST_LSB 8
`define MAIW_IRQ_WRAP 0
`define MAIW_IRQ_FAULT 1
`define MAIW_IRQ_CONV 2
`define MAIW_NIRQ 3
`define MAIW_NCH 8
`define MAIW_DATA_W 12
`define MAIW_ID_LSB 12
`define MAIW_ID_MSB 14
`define MAIW_SIGN_BIT 15
`define MAIW_FULL 12'hFFF
`define MAIW_SETTLE_MS 4
`define MAIW_SETTLE_PCT 95
`define MAIW_FILT_SHIFT 2
`define MAIW_RESP_OK 2'h0
`define MAIW_RESP_ERR 2'h2
`endif

// [hw/maiw_pkg.sv]
package maiw_pkg;
    typedef logic [11:0] maiw_mag_t;
    typedef logic [2:0] maiw_ch_t;
    typedef logic signed [13:0] maiw_acc_t;
    typedef logic [15:0] maiw_word_t;
    typedef enum logic {MAIW_MUX, MAIW_PTR} maiw_mode_t;
endpackage
